/* File: logic/cap_timer_pkg.sv */
// Purpose: constants and types for the buffered capture timer core
// Assumes: axi4-lite register access, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
package cap_timer_pkg;
  localparam logic [7:0] ADDR_DIR_SEL  = 8'h80; // channel_direction_select
  localparam logic [7:0] ADDR_CNT      = 8'h84; // main counter, read only
  localparam logic [7:0] ADDR_CTRL     = 8'h88; // enable, prescale, saturate...
  localparam logic [7:0] ADDR_EDGE     = 8'h8c; // 16 edge select bits
  localparam logic [7:0] ADDR_COMPARE  = 8'h90; // compare match, 8 bits
  localparam logic [7:0] ADDR_NOVW     = 8'h94; // capture_overwrite_control
  localparam logic [7:0] ADDR_MOD_CTL  = 8'h98; // modulus_control
  localparam logic [7:0] ADDR_MOD_CNT  = 8'h9c; // modulus load / count
  localparam logic [7:0] ADDR_PORT     = 8'ha0; // timer_port_data
  localparam logic [7:0] ADDR_DDR      = 8'ha4; // port direction
  localparam logic [7:0] ADDR_EMPTY    = 8'ha8; // empty status
  localparam logic [7:0] ADDR_CH_BASE  = 8'hc0; // capture 0..7, 4 bytes each
  localparam logic [7:0] ADDR_HOLD_BASE = 8'he0; // holding 4..7
  localparam logic [7:0] ADDR_PACC     = 8'hf0; // four accumulators
  localparam logic [7:0] ADDR_PACC_HOLD = 8'hf4; // four accumulator holds
  localparam int         NUM_CH        = 8;
  localparam int         NUM_BUF       = 4;
  localparam logic [7:0] DIR_SEL_RESET = 8'h00;
  localparam logic [15:0] MOD_RESET    = 16'h0000;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;
  localparam logic [1:0] EDGE_OFF      = 2'b00;
  localparam logic [1:0] EDGE_RISE     = 2'b01;
  localparam logic [1:0] EDGE_FALL     = 2'b10;
  localparam logic [1:0] EDGE_ANY      = 2'b11;

  // control word layout
  typedef struct packed {
    logic [23:0] unused;
    logic        acc_pair_hi;   // pair 6/7 as 16 bits
    logic        acc_pair_lo;   // pair 4/5 as 16 bits
    logic        accumulator_saturate_bit;
    logic        latch_queue_select;
    logic [2:0]  main_prescale; // divide by 2**n, up to 128
    logic        timer_enable;
  } ctrl_t;

  typedef struct packed {
    logic [26:0] unused;
    logic        mod_enable;
    logic        mod_periodic;  // 0: latch only once
    logic [1:0]  mod_prescale;  // divide by 1,4,8,16
    logic        unused0;
  } mod_ctl_t;

  typedef struct packed {
    logic [7:0]  capture;
    logic [3:0]  holding;
  } empty_t;
endpackage

/* File: logic/cap_timer_core.sv */
// Purpose: eight-channel capture/compare timer with buffered channels
// Assumes: timer pins synchronous to aclk; one outstanding access per channel
// Notes: axi4-lite slave, answers one cycle after both halves arrive
`timescale 1ns/100ps
`default_nettype none
module cap_timer_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  timer_pin_in,
  output logic [7:0]       timer_pin_out,
  output logic [7:0]       timer_pin_oe,
  output logic             modulus_zero
);
  // ---------------- bus slave
  logic        aw_q, w_q, ar_hold_q;
  logic [7:0]  awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go, rd_go;
  logic [31:0] rdata_d;
  logic        rd_ok, wr_ok;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !ar_hold_q && !s_axi_rvalid;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign rd_go = ar_hold_q && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cap_timer_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? cap_timer_pkg::RESP_OKAY
                           : cap_timer_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_hold_q <= 1'b0;
      araddr_q <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cap_timer_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_hold_q <= 1'b1;
        araddr_q <= s_axi_araddr;
      end else if (rd_go) begin
        ar_hold_q <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_ok ? cap_timer_pkg::RESP_OKAY
                             : cap_timer_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // merge byte lanes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic wr_at(input logic [7:0] a);
    return wr_go && (awaddr_q == a);
  endfunction

  // ---------------- registers
  logic [7:0]              dir_sel_q, novw_q, port_q, ddr_q, cmp_q;
  logic [15:0]             edge_q, mod_load_q, mod_cnt_q, main_cnt_q;
  cap_timer_pkg::ctrl_t    ctrl_q;
  cap_timer_pkg::mod_ctl_t modc_q;
  logic                    force_latch, mod_zero_wr;

  // force latch is a pulse on any write of 1 to bit 4 of the modulus control word, which also stores the enable
  assign force_latch = wr_at(cap_timer_pkg::ADDR_MOD_CTL) && wstrb_q[0]
                       && wdata_q[4];
  assign mod_zero_wr = wr_at(cap_timer_pkg::ADDR_MOD_CNT)
                       && (merge({16'h0000, mod_load_q}, wdata_q, wstrb_q)
                           == 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_sel_q <= cap_timer_pkg::DIR_SEL_RESET;
      novw_q <= 8'h00;
      port_q <= 8'h00;
      ddr_q <= 8'h00;
      cmp_q <= 8'h00;
      edge_q <= 16'h0000;
      ctrl_q <= '0;
      modc_q <= '0;
      mod_load_q <= cap_timer_pkg::MOD_RESET;
    end else if (wr_go) begin
      case (awaddr_q)
        cap_timer_pkg::ADDR_DIR_SEL:
          dir_sel_q <= 8'(merge({24'h0, dir_sel_q}, wdata_q,
                                wstrb_q));
        cap_timer_pkg::ADDR_NOVW:
          novw_q <= 8'(merge({24'h0, novw_q}, wdata_q, wstrb_q));
        cap_timer_pkg::ADDR_PORT:
          port_q <= 8'(merge({24'h0, port_q}, wdata_q, wstrb_q));
        cap_timer_pkg::ADDR_DDR:
          ddr_q <= 8'(merge({24'h0, ddr_q}, wdata_q, wstrb_q));
        cap_timer_pkg::ADDR_COMPARE:
          cmp_q <= 8'(merge({24'h0, cmp_q}, wdata_q, wstrb_q));
        cap_timer_pkg::ADDR_EDGE:
          edge_q <= 16'(merge({16'h0, edge_q}, wdata_q, wstrb_q));
        cap_timer_pkg::ADDR_CTRL:
          ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        cap_timer_pkg::ADDR_MOD_CTL:
          // bit 4 is kept as the enable; its write also fires the latch
          modc_q <= merge(modc_q, wdata_q, wstrb_q) & 32'h0000_001e;
        cap_timer_pkg::ADDR_MOD_CNT:
          mod_load_q <= 16'(merge({16'h0, mod_load_q}, wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  // ---------------- main counter, 7-bit prescaler
  logic [6:0] main_pre_q;
  logic       main_tick;
  assign main_tick = ctrl_q.timer_enable &&
    ((main_pre_q & ((7'h01 << ctrl_q.main_prescale) - 7'h01)) == 7'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_pre_q <= 7'h00;
      main_cnt_q <= 16'h0000;
    end else if (ctrl_q.timer_enable) begin
      main_pre_q <= main_pre_q + 7'h01;
      if (main_tick) main_cnt_q <= main_cnt_q + 16'h0001;
    end
  end

  // ---------------- modulus down-counter, 4-bit prescaler
  logic [3:0] mod_pre_q;
  logic       mod_tick, mod_hit, latch_ev;
  logic       mod_armed_q;
  assign mod_tick = modc_q.mod_enable && (mod_pre_q == 4'h0);
  assign mod_hit = mod_tick && (mod_cnt_q == 16'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_pre_q <= 4'h0;
      mod_cnt_q <= cap_timer_pkg::MOD_RESET;
      mod_armed_q <= 1'b1;
    end else begin
      if (wr_at(cap_timer_pkg::ADDR_MOD_CNT)) begin
        mod_cnt_q <= 16'(merge({16'h0, mod_load_q}, wdata_q, wstrb_q));
        mod_pre_q <= 4'h0;
        mod_armed_q <= 1'b1;
      end else if (modc_q.mod_enable) begin
        case (modc_q.mod_prescale)
          2'b00: mod_pre_q <= 4'h0;
          2'b01: mod_pre_q <= (mod_pre_q == 4'h3) ? 4'h0 : mod_pre_q + 4'h1;
          2'b10: mod_pre_q <= (mod_pre_q == 4'h7) ? 4'h0 : mod_pre_q + 4'h1;
          default: mod_pre_q <= mod_pre_q + 4'h1;
        endcase
        if (mod_tick && mod_cnt_q != 16'h0000) begin
          if (mod_hit && modc_q.mod_periodic)
            mod_cnt_q <= mod_load_q;
          else
            mod_cnt_q <= mod_cnt_q - 16'h0001;
        end
        if (mod_hit && !modc_q.mod_periodic) mod_armed_q <= 1'b0;
      end
    end
  end

  // one-shot mode latches only on the first zero after a load
  assign latch_ev = (mod_hit && mod_armed_q) || mod_zero_wr
                    || force_latch;

  always_ff @(posedge aclk) begin
    if (!aresetn) modulus_zero <= 1'b0;
    else modulus_zero <= mod_hit;
  end

  // ---------------- edge detect and capture
  logic [7:0] pin_q, edge_ev;
  always_ff @(posedge aclk) begin
    if (!aresetn) pin_q <= 8'h00;
    else pin_q <= timer_pin_in;
  end

  always_comb begin
    for (int i = 0; i < cap_timer_pkg::NUM_CH; i++) begin
      case (edge_q[2*i +: 2])
        cap_timer_pkg::EDGE_RISE: edge_ev[i] = timer_pin_in[i] && !pin_q[i];
        cap_timer_pkg::EDGE_FALL: edge_ev[i] = !timer_pin_in[i] && pin_q[i];
        cap_timer_pkg::EDGE_ANY:  edge_ev[i] = timer_pin_in[i] ^ pin_q[i];
        default:                  edge_ev[i] = 1'b0;
      endcase
      edge_ev[i] = edge_ev[i] && !dir_sel_q[i];
    end
  end

  logic [15:0] cap_q [8];
  logic [15:0] hold_q [4];
  logic [7:0]  cap_empty_q;
  logic [3:0]  hold_empty_q;
  logic [7:0]  cap_rd;
  logic [3:0]  hold_rd;

  always_comb begin
    for (int i = 0; i < 8; i++)
      cap_rd[i] = rd_go && (araddr_q == cap_timer_pkg::ADDR_CH_BASE
                            + 8'(4 * i));
    for (int j = 0; j < 4; j++)
      hold_rd[j] = rd_go && (araddr_q == cap_timer_pkg::ADDR_HOLD_BASE
                             + 8'(4 * j));
  end

  // fixed order per cycle on channels 4..7: read empties first, then latch, then capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) cap_q[i] <= 16'h0000;
      for (int j = 0; j < 4; j++) hold_q[j] <= 16'h0000;
      cap_empty_q <= 8'hff;
      hold_empty_q <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap_rd[i]) cap_empty_q[i] <= 1'b1;
        if (edge_ev[i] && (!novw_q[i] || cap_empty_q[i])) begin
          cap_q[i] <= main_cnt_q;
          cap_empty_q[i] <= 1'b0;
        end
      end
      for (int j = 0; j < 4; j++) begin : buf_ch
        logic ce, he, nv, moved;
        ce = cap_empty_q[j+4];
        he = hold_empty_q[j];
        nv = novw_q[j+4];
        moved = 1'b0;
        if (cap_rd[j+4]) ce = 1'b1;
        if (hold_rd[j]) he = 1'b1;
        if (ctrl_q.latch_queue_select) begin
          if (latch_ev && !ce && (!nv || he)) begin
            hold_q[j] <= cap_q[j+4];
            he = 1'b0;
            ce = 1'b1;
          end
          if (edge_ev[j+4] && (!nv || ce)) begin
            cap_q[j+4] <= main_cnt_q;
            ce = 1'b0;
          end
        end else if (edge_ev[j+4]) begin
          if (!nv || (he && !ce)) begin
            if (!ce) begin
              hold_q[j] <= cap_q[j+4];
              he = 1'b0;
            end
            moved = 1'b1;
          end
          if (moved || (nv && ce)) begin
            cap_q[j+4] <= main_cnt_q;
            ce = 1'b0;
          end
        end
        cap_empty_q[j+4] <= ce;
        hold_empty_q[j] <= he;
      end
    end
  end

  // ---------------- pulse accumulators
  logic [7:0] acc_q [4];
  logic [7:0] acc_hold_q [4];
  logic [3:0] acc_xfer;
  logic [1:0] pair_en;
  assign pair_en = {ctrl_q.acc_pair_hi, ctrl_q.acc_pair_lo};

  always_comb begin
    for (int j = 0; j < 4; j++)
      acc_xfer[j] = ctrl_q.latch_queue_select ? latch_ev
                  : hold_rd[j];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int j = 0; j < 4; j++) begin
        acc_q[j] <= 8'h00;
        acc_hold_q[j] <= 8'h00;
      end
    end else begin
      for (int j = 0; j < 4; j++) begin : acc_ch
        logic inc, sat;
        // in pair mode the odd half counts carries of the even half
        if (pair_en[j/2] && j[0])
          inc = edge_ev[j+3] && (acc_q[j-1] == 8'hff);
        else
          inc = edge_ev[j+4];
        sat = ctrl_q.accumulator_saturate_bit && !pair_en[j/2]
              && acc_q[j] == 8'hff;
        if (acc_xfer[j]) begin
          acc_hold_q[j] <= acc_q[j];
          acc_q[j] <= 8'h00;
        end else if (inc && !sat) begin
          acc_q[j] <= acc_q[j] + 8'h01;
        end
      end
    end
  end

  // ---------------- pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_pin_out <= 8'h00;
      timer_pin_oe <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (dir_sel_q[i]) begin
          timer_pin_oe[i] <= 1'b1;
          if (cmp_q[i] == 1'b1 && main_cnt_q == cap_q[i])
            timer_pin_out[i] <= ~timer_pin_out[i];
        end else begin
          timer_pin_oe[i] <= ddr_q[i];
          timer_pin_out[i] <= port_q[i];
        end
      end
    end
  end

  // ---------------- read mux
  always_comb begin
    rd_ok = 1'b1;
    rdata_d = 32'h0000_0000;
    case (araddr_q)
      cap_timer_pkg::ADDR_DIR_SEL: rdata_d = {24'h0, dir_sel_q};
      cap_timer_pkg::ADDR_CNT:     rdata_d = {16'h0, main_cnt_q};
      cap_timer_pkg::ADDR_CTRL:    rdata_d = ctrl_q;
      cap_timer_pkg::ADDR_EDGE:    rdata_d = {16'h0, edge_q};
      cap_timer_pkg::ADDR_COMPARE: rdata_d = {24'h0, cmp_q};
      cap_timer_pkg::ADDR_NOVW:    rdata_d = {24'h0, novw_q};
      cap_timer_pkg::ADDR_MOD_CTL: rdata_d = modc_q;
      cap_timer_pkg::ADDR_MOD_CNT: rdata_d = {16'h0, mod_cnt_q};
      cap_timer_pkg::ADDR_PORT:    rdata_d = {24'h0, port_q};
      cap_timer_pkg::ADDR_DDR:     rdata_d = {24'h0, ddr_q};
      cap_timer_pkg::ADDR_EMPTY:   rdata_d = {20'h0, hold_empty_q, cap_empty_q};
      cap_timer_pkg::ADDR_PACC:
        rdata_d = {acc_q[3], acc_q[2], acc_q[1], acc_q[0]};
      cap_timer_pkg::ADDR_PACC_HOLD:
        rdata_d = {acc_hold_q[3], acc_hold_q[2], acc_hold_q[1], acc_hold_q[0]};
      default: begin
        rd_ok = 1'b0;
        for (int i = 0; i < 8; i++)
          if (cap_rd[i]) begin
            rdata_d = {16'h0, cap_q[i]};
            rd_ok = 1'b1;
          end
        for (int j = 0; j < 4; j++)
          if (hold_rd[j]) begin
            rdata_d = {16'h0, hold_q[j]};
            rd_ok = 1'b1;
          end
      end
    endcase
  end

  always_comb begin
    case (awaddr_q)
      cap_timer_pkg::ADDR_DIR_SEL, cap_timer_pkg::ADDR_CTRL,
      cap_timer_pkg::ADDR_EDGE, cap_timer_pkg::ADDR_COMPARE,
      cap_timer_pkg::ADDR_NOVW, cap_timer_pkg::ADDR_MOD_CTL,
      cap_timer_pkg::ADDR_MOD_CNT, cap_timer_pkg::ADDR_PORT,
      cap_timer_pkg::ADDR_DDR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ---------------- assertions
  sequence s_latch_cap;
    ctrl_q.latch_queue_select && latch_ev && !cap_empty_q[4]
    && !novw_q[4] && !cap_rd[4];
  endsequence
  property p_latch_copy;
    @(posedge aclk) disable iff (!aresetn)
      s_latch_cap |=> hold_q[0] == $past(cap_q[4]);
  endproperty
  a_latch_copy: assert property (p_latch_copy)
    else $error("latch did not copy capture to holding");

  property p_novw_block;
    @(posedge aclk) disable iff (!aresetn)
      novw_q[0] && !cap_empty_q[0] && !cap_rd[0] |=> $stable(cap_q[0]);
  endproperty
  a_novw_block: assert property (p_novw_block)
    else $error("full capture register overwritten");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
      edge_ev[1] && !novw_q[1] |=> cap_q[1] == $past(main_cnt_q);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture missed counter value");

  property p_read_empty;
    @(posedge aclk) disable iff (!aresetn)
      hold_rd[1] && !(edge_ev[5] && !ctrl_q.latch_queue_select)
      && !latch_ev |=> hold_empty_q[1];
  endproperty
  a_read_empty: assert property (p_read_empty)
    else $error("holding not empty after read");

  property p_acc_clear;
    @(posedge aclk) disable iff (!aresetn)
      acc_xfer[2] |=> acc_q[2] == 8'h00 && acc_hold_q[2] == $past(acc_q[2]);
  endproperty
  a_acc_clear: assert property (p_acc_clear)
    else $error("accumulator transfer wrong");

  property p_saturate;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_q.accumulator_saturate_bit && !pair_en[0] && acc_q[0] == 8'hff
      && !acc_xfer[0] |=> acc_q[0] == 8'hff;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("accumulator wrapped while saturating");

  property p_compare_oe;
    @(posedge aclk) disable iff (!aresetn)
      dir_sel_q[3] |=> timer_pin_oe[3];
  endproperty
  a_compare_oe: assert property (p_compare_oe)
    else $error("compare pin not driven");

  property p_port_latch;
    @(posedge aclk) disable iff (!aresetn)
      !dir_sel_q[2] ##1 !dir_sel_q[2] |-> timer_pin_out[2] == $past(port_q[2]);
  endproperty
  a_port_latch: assert property (p_port_latch)
    else $error("port latch not driven");

  property p_queue_push;
    @(posedge aclk) disable iff (!aresetn)
      !ctrl_q.latch_queue_select && edge_ev[6] && !novw_q[6]
      && !cap_empty_q[6] && !cap_rd[6] |=> hold_q[2] == $past(cap_q[6]);
  endproperty
  a_queue_push: assert property (p_queue_push)
    else $error("queue did not push old capture");
endmodule
`default_nettype wire

/* File: bench/pin_source.sv */
// Purpose: far-side pin driver for the capture timer
// Assumes: pins idle low between pulses
// Notes: pulse is two cycles high so every edge detector sees it
`timescale 1ns/100ps
`default_nettype none
module pin_source (
  input  wire logic       aclk,
  input  wire logic [7:0] mask,
  input  wire logic       go,
  output logic [7:0]      pins
);
  logic [1:0] ph_q = 2'h0;
  always_ff @(posedge aclk) begin
    ph_q <= go ? 2'h3 : (ph_q != 2'h0 ? ph_q - 2'h1 : 2'h0);
  end
  assign pins = ph_q[1] ? mask : 8'h00;
endmodule
`default_nettype wire

/* File: bench/buffered_capture_timer_core_tb.sv */
// Purpose: self-checking bench for the capture timer core
// Assumes: axi4-lite master waits for each answer under a bound
// Notes: counter values are not predicted, only status and counts
`timescale 1ns/100ps
`default_nettype none
module buffered_capture_timer_core_tb;
  logic        aclk = 0, aresetn = 0, go = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, mask = 8'h00, pins;
  logic [7:0]  pout, poe;
  logic        mz;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs, bs;
  int          err_count = 0, samples_checked = 0;
  always #25 aclk = ~aclk;
  pin_source src (.aclk(aclk), .mask(mask), .go(go), .pins(pins));
  cap_timer_core dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_pin_in(pins),
    .timer_pin_out(pout), .timer_pin_oe(poe), .modulus_zero(mz));
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && n < 50);
    bs = bresp;
    // bready stays high between writes so no step assigns it twice
    if (n >= 50) begin err_count++; tally_and_finish(); end
  endtask
  task automatic rdw(logic [7:0] a);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (!rvalid && n < 50);
    rd = rdata;
    rs = rresp;
    if (n >= 50) begin err_count++; tally_and_finish(); end
  endtask
  task automatic pulse(logic [7:0] m);
    mask <= m; go <= 1;
    @(posedge aclk);
    go <= 0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic t_regs();
    rdw(8'h80); check("dir reset", rd, 32'h0);
    wr(8'h80, 32'ha0);
    rdw(8'h80); check("dir rw", rd, 32'ha0);
    rdw(8'h7c); check("unmapped resp", {30'h0, rs}, 32'h2);
    wr(8'h7c, 32'h1);
    check("unmapped wr", {30'h0, bs}, 32'h2);
    rdw(8'h84);
    check("cnt word hi", rd >> 16, 32'h0);
  endtask
  task automatic count_zero(int cycles, output int k);
    k = 0;
    repeat (cycles) begin
      @(posedge aclk);
      if (mz === 1'b1) k++;
    end
  endtask
  task automatic t_pins();
    wr(8'ha4, 32'h04);
    wr(8'ha0, 32'h24);
    wr(8'h80, 32'h28);
    repeat (2) @(posedge aclk);
    check("oe compare", {24'h0, poe}, 32'h2c);
    check("out latched", {24'h0, pout}, 32'h04);
    wr(8'h80, 32'h00);
    repeat (2) @(posedge aclk);
    check("oe ddr", {24'h0, poe}, 32'h04);
    check("out released", {24'h0, pout}, 32'h24);
  endtask
  task automatic t_queue();
    logic [31:0] v0;
    wr(8'h88, 32'h01);
    wr(8'h8c, 32'h1105);
    wr(8'h94, 32'h01);
    pulse(8'h43);
    pulse(8'h43);
    rdw(8'ha8);
    check("queue full", rd & 32'h443, 32'h0);
    rdw(8'hc0);
    v0 = rd;
    rdw(8'hc4);
    check("novw keeps first", rd - v0, 32'h6);
    rdw(8'he8);
    rdw(8'hf4);
    check("q acc hold", (rd >> 16) & 32'hff, 32'h2);
    rdw(8'hf0);
    check("q acc clr", (rd >> 16) & 32'hff, 32'h0);
    rdw(8'he4);
    rdw(8'ha8);
    check("hold empty", rd & 32'h600, 32'h600);
  endtask
  task automatic t_sat();
    wr(8'h88, 32'h21);
    repeat (256) pulse(8'h10);
    rdw(8'hf0);
    check("acc sat", rd & 32'hff, 32'hff);
    wr(8'h88, 32'h41);
    pulse(8'h10);
    rdw(8'hf0);
    check("acc pair", rd & 32'hffff, 32'h100);
  endtask
  task automatic t_mod();
    int k;
    wr(8'h9c, 32'h3);
    count_zero(12, k);
    check("one shot", k, 1);
    wr(8'h98, 32'h18);
    wr(8'h9c, 32'h3);
    repeat (3) @(posedge aclk);
    count_zero(12, k);
    check("periodic", k, 4);
  endtask
  task automatic t_capture();
    wr(8'h88, 32'h11); // enable, latch mode
    wr(8'h8c, 32'h101); // rising edges on channels 0 and 4
    pulse(8'h01);
    rdw(8'ha8); check("cap full", rd & 32'h1, 32'h0);
    rdw(8'hc0);
    rdw(8'ha8); check("cap empty", rd & 32'h1, 32'h1);
  endtask
  task automatic t_acc();
    repeat (3) pulse(8'h10);
    rdw(8'hf0); check("acc count", rd & 32'hff, 32'h3);
    wr(8'h98, 32'h10); // force latch
    rdw(8'hf4); check("acc hold", rd & 32'hff, 32'h3);
    rdw(8'hf0); check("acc clr", rd & 32'hff, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_capture();
    t_acc();
    t_pins();
    t_queue();
    t_sat();
    t_mod();
    tally_and_finish();
  end
endmodule
`default_nettype wire
